// ### core/csf_status_core.sv
// Status-flag, second-accumulator and instruction-timing logic of the core
// What this block does
// - All timing counted in plain system clocks; peak one instruction per clock.
// - Most instructions take as many clocks as they have program bytes.
// - A conditional branch not taken takes one clock fewer than taken.
// - Flag effects of arithmetic match the classic instruction set exactly.
// - Eight-bit second accumulator, software read/write, product/quotient operand, reset zero.
// - Status bit 7 carry: set on carry or borrow, else cleared by arithmetic.
// - Status bit 6 nibble carry: set on carry/borrow at bit 3 boundary.
// - Status bits 5 and 1 are software flags hardware never touches.
// - Bits 4:3 pick one of four eight-byte register banks.
// - Overflow set on signed overflow, product above 255, or divide by zero.
// - Otherwise those five instructions clear the overflow bit 2.
// - Read-only bit 0 is one when accumulator has odd set bits.
`timescale 1ns/1ps
module csf_status_core
  import csf_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         arst_n_i,
  // Special-register port
  input  wire csf_sfr_req_s sfr_i,
  output logic [7:0]        sfr_rdata_o,
  // Accumulator load from the core
  input  wire logic         acc_wr_i,
  input  wire logic [7:0]   acc_wdata_i,
  // Arithmetic request
  input  wire csf_alu_req_s alu_i,
  // Instruction timing
  input  wire csf_instr_s   instr_i,
  output logic              instr_ready_o,
  output logic              instr_done_o,
  // State
  output logic [7:0]        acc_o,
  output logic [7:0]        b_o,
  output logic [7:0]        psw_o,
  output logic [4:0]        bank_base_o
);

  // ==================================================================
  // Arithmetic
  logic [7:0]  acc_q;
  logic [7:0]  b_q;
  logic [7:0]  psw_q;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [8:0]  dif9;
  logic [4:0]  dif5;
  logic [15:0] prod;
  logic        div_zero;
  logic [7:0]  quot;
  logic [7:0]  rem;
  logic        alu_go;

  assign alu_go = alu_i.valid && (alu_i.op != CSF_OP_NONE);

  always_comb begin
    cin  = ((alu_i.op == CSF_OP_SUM_WITH_CARRY_INSTR) || (alu_i.op == CSF_OP_SUBTRACT_BORROW_INSTR)) ? psw_q[CSF_CY_BIT] : 1'b0;
    sum9 = {1'b0, acc_q} + {1'b0, alu_i.src} + {8'h00, cin};
    sum5 = {1'b0, acc_q[3:0]} + {1'b0, alu_i.src[3:0]} + {4'h0, cin};
    dif9 = {1'b0, acc_q} - {1'b0, alu_i.src} - {8'h00, cin};
    dif5 = {1'b0, acc_q[3:0]} - {1'b0, alu_i.src[3:0]} - {4'h0, cin};
    prod = acc_q * b_q;
    div_zero = (b_q == 8'h00);
    // Divider guarded so the zero case never reaches the operator
    quot = div_zero ? acc_q : acc_q / b_q;
    rem  = div_zero ? b_q : acc_q % b_q;
  end

  // ==================================================================
  // Accumulator and second accumulator
  logic [7:0] acc_d;
  logic [7:0] b_d;

  always_comb begin
    acc_d = acc_q;
    if (acc_wr_i) begin
      acc_d = acc_wdata_i;
    end
    // Arithmetic result wins over a plain load in the same clock
    if (alu_i.valid) begin
      case (alu_i.op)
        CSF_OP_ADD, CSF_OP_SUM_WITH_CARRY_INSTR: acc_d = sum9[7:0];
        CSF_OP_SUBTRACT_BORROW_INSTR:             acc_d = dif9[7:0];
        CSF_OP_MUL:              acc_d = prod[7:0];
        CSF_OP_DIV:              acc_d = quot;
        default:                 acc_d = acc_d;
      endcase
    end
  end

  always_comb begin
    b_d = b_q;
    if (sfr_i.wr && (sfr_i.addr == CSF_B_ADDR)) begin
      b_d = sfr_i.wdata;
    end else if (sfr_i.bit_wr && (sfr_i.addr == CSF_B_ADDR)) begin
      b_d[sfr_i.bit_idx] = sfr_i.bit_val;
    end
    if (alu_i.valid && (alu_i.op == CSF_OP_MUL)) begin
      b_d = prod[15:8];
    end else if (alu_i.valid && (alu_i.op == CSF_OP_DIV)) begin
      b_d = rem;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= CSF_ACC_RESET;
      b_q   <= CSF_B_RESET;
    end else begin
      acc_q <= acc_d;
      b_q   <= b_d;
    end
  end

  // ==================================================================
  // Status word
  logic [7:0] psw_d;

  always_comb begin
    psw_d = psw_q;
    if (sfr_i.wr && (sfr_i.addr == CSF_PSW_ADDR)) begin
      psw_d = (sfr_i.wdata & CSF_PSW_WMASK) | (psw_q & ~CSF_PSW_WMASK);
    end else if (sfr_i.bit_wr && (sfr_i.addr == CSF_PSW_ADDR) &&
                 (sfr_i.bit_idx != 3'(CSF_PAR_BIT))) begin
      psw_d[sfr_i.bit_idx] = sfr_i.bit_val;
    end
    // Hardware flag updates win over a software write in the same clock
    if (alu_i.valid) begin
      case (alu_i.op)
        CSF_OP_ADD, CSF_OP_SUM_WITH_CARRY_INSTR: begin
          psw_d[CSF_CY_BIT] = sum9[8];
          psw_d[CSF_AC_BIT] = sum5[4];
          psw_d[CSF_OV_BIT] = (acc_q[7] == alu_i.src[7]) && (sum9[7] != acc_q[7]);
        end
        CSF_OP_SUBTRACT_BORROW_INSTR: begin
          psw_d[CSF_CY_BIT] = dif9[8];
          psw_d[CSF_AC_BIT] = dif5[4];
          psw_d[CSF_OV_BIT] = (acc_q[7] != alu_i.src[7]) && (dif9[7] != acc_q[7]);
        end
        CSF_OP_MUL: begin
          psw_d[CSF_CY_BIT] = 1'b0;
          psw_d[CSF_OV_BIT] = (prod > {8'h00, CSF_PROD_MAX});
        end
        CSF_OP_DIV: begin
          psw_d[CSF_CY_BIT] = 1'b0;
          psw_d[CSF_OV_BIT] = div_zero;
        end
        default: psw_d = psw_d;
      endcase
    end
    psw_d[CSF_PAR_BIT] = ^acc_d;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      psw_q <= CSF_PSW_RESET;
    end else begin
      psw_q <= psw_d;
    end
  end

  // ==================================================================
  // Outputs and register reads
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_o       <= CSF_ACC_RESET;
      b_o         <= CSF_B_RESET;
      psw_o       <= CSF_PSW_RESET;
      bank_base_o <= 5'h00;
    end else begin
      acc_o       <= acc_d;
      b_o         <= b_d;
      psw_o       <= psw_d;
      bank_base_o <= {psw_d[CSF_RS_HI:CSF_RS_LO], 3'h0};
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_i.rd) begin
      case (sfr_i.addr)
        CSF_PSW_ADDR: sfr_rdata_o <= psw_q;
        CSF_B_ADDR:   sfr_rdata_o <= b_q;
        default:      sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==================================================================
  // Instruction timing
  logic [CSF_CNT_W-1:0] instr_cycles;
  logic                 instr_take;

  assign instr_take = instr_i.valid && instr_ready_o;

  always_comb begin
    // Byte count sets the clocks; a taken branch adds one
    instr_cycles = CSF_CNT_W'(instr_i.bytes) * CSF_CNT_W'(CSF_CYC_PER_BYTE);
    if (instr_i.cond_branch && instr_i.taken) begin
      instr_cycles = instr_cycles + CSF_CNT_W'(CSF_BRANCH_TAKEN_ADD);
    end
  end

  csf_instr_timer #(
    .CNT_W (CSF_CNT_W)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .load_i    (instr_take),
    .cycles_i  (instr_cycles),
    .ready_o   (instr_ready_o),
    .done_o    (instr_done_o)
  );

  // ==================================================================
  // Checks
  sequence s_take(int unsigned n, bit cb, bit tk);
    instr_take && (instr_i.bytes == n) && (instr_i.cond_branch == cb) && (instr_i.taken == tk);
  endsequence

  a_one_byte_time: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_take(1, 0, 0) |=> ##1 instr_done_o) else $error("one-byte instruction not done in 1 clock");
  // Done is registered, so it is seen one edge after the last busy clock
  a_branch_not_taken: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_take(2, 1, 0) |=> ##1 !instr_done_o ##1 instr_done_o)
    else $error("untaken branch timing wrong");
  a_branch_taken: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_take(2, 1, 1) |=> ##1 (!instr_done_o)[*2] ##1 instr_done_o)
    else $error("taken branch timing wrong");
  a_add_carry: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    alu_i.valid && (alu_i.op == CSF_OP_ADD)
      |=> psw_q[CSF_CY_BIT] == ($past(acc_q) + $past(alu_i.src) > 9'h0FF))
    else $error("carry wrong after add");
  a_sub_nibble: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    alu_i.valid && (alu_i.op == CSF_OP_SUBTRACT_BORROW_INSTR)
      |=> psw_q[CSF_AC_BIT] == ($past(dif5) > 5'h0F)) else $error("nibble borrow wrong");
  a_mul_overflow: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    alu_i.valid && (alu_i.op == CSF_OP_MUL)
      |=> psw_q[CSF_OV_BIT] == (b_q != 8'h00) && !psw_q[CSF_CY_BIT])
    else $error("product overflow wrong");
  a_div_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    alu_i.valid && (alu_i.op == CSF_OP_DIV)
      |=> psw_q[CSF_OV_BIT] == ($past(b_q) == 8'h00)) else $error("divide overflow wrong");
  a_parity_track: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    psw_o[CSF_PAR_BIT] == ^acc_o) else $error("parity does not follow accumulator");
  a_user_flags: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !(sfr_i.wr || sfr_i.bit_wr) |=> $stable(psw_q[CSF_UF0_BIT]) && $stable(psw_q[CSF_UF1_BIT]))
    else $error("user flag changed by hardware");
  a_bank_select: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    bank_base_o == {psw_o[CSF_RS_HI:CSF_RS_LO], 3'h0}) else $error("bank base mismatch");
  a_b_write: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    sfr_i.wr && (sfr_i.addr == CSF_B_ADDR) && !alu_i.valid |=> b_o == $past(sfr_i.wdata))
    else $error("second accumulator write lost");
  a_psw_write: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    sfr_i.wr && (sfr_i.addr == CSF_PSW_ADDR) && !alu_i.valid
      |=> psw_q[7:1] == $past(sfr_i.wdata[7:1])) else $error("status write wrong");

endmodule

// ### core/csf_pkg.sv
// Package: constants, operation codes and carrier structs for the status-flag block
package csf_pkg;

  // ==================================================================
  // Register map
  localparam logic [7:0] CSF_PSW_ADDR   = 8'hD0;
  localparam logic [7:0] CSF_B_ADDR     = 8'hF0;
  localparam logic [7:0] CSF_PSW_RESET  = 8'h00;
  localparam logic [7:0] CSF_B_RESET    = 8'h00;
  localparam logic [7:0] CSF_ACC_RESET  = 8'h00;
  localparam logic [7:0] CSF_PSW_WMASK  = 8'hFE;

  // ==================================================================
  // Status word field positions
  localparam int CSF_CY_BIT  = 7;
  localparam int CSF_AC_BIT  = 6;
  localparam int CSF_UF0_BIT = 5;
  localparam int CSF_RS_HI   = 4;
  localparam int CSF_RS_LO   = 3;
  localparam int CSF_OV_BIT  = 2;
  localparam int CSF_UF1_BIT = 1;
  localparam int CSF_PAR_BIT = 0;

  // ==================================================================
  // Timing
  localparam int CSF_MAX_CLK_MHZ      = 25;
  localparam int CSF_SYS_CLK_MHZ      = 20;
  localparam int CSF_CYC_PER_BYTE     = 1;
  localparam int CSF_BRANCH_TAKEN_ADD = 1;
  localparam int CSF_CNT_W            = 3;
  localparam logic [7:0] CSF_PROD_MAX = 8'hFF;

  // ==================================================================
  // Arithmetic operations
  typedef enum logic [5:0] {
    CSF_OP_NONE = 6'h01,
    CSF_OP_ADD  = 6'h02,
    CSF_OP_SUM_WITH_CARRY_INSTR = 6'h04,
    CSF_OP_SUBTRACT_BORROW_INSTR = 6'h08,
    CSF_OP_MUL  = 6'h10,
    CSF_OP_DIV  = 6'h20
  } csf_op_e;

  typedef struct packed {
    logic       valid;
    csf_op_e    op;
    logic [7:0] src;
  } csf_alu_req_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] bytes;
    logic       cond_branch;
    logic       taken;
  } csf_instr_s;

  typedef struct packed {
    logic       wr;
    logic       bit_wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_idx;
    logic       bit_val;
  } csf_sfr_req_s;

endpackage

// ### core/csf_instr_timer.sv
// Instruction cycle counter: busy for a loaded number of clocks, then a done pulse
`timescale 1ns/1ps
module csf_instr_timer
  import csf_pkg::*;
#(
  parameter int CNT_W = CSF_CNT_W
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  // Load
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] cycles_i,
  // Status
  output logic                  ready_o,
  output logic                  done_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    if (load_i) begin
      cnt_d = cycles_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q   <= '0;
      done_o  <= 1'b0;
      ready_o <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      done_o  <= (cnt_q == CNT_W'(1));
      // Ready in the last cycle so single-byte work issues every clock
      ready_o <= (cnt_d <= CNT_W'(1));
    end
  end

endmodule

// ### dv/testbench.sv
// Self-checking bench for the status-flag and instruction-timing core
`timescale 1ns/1ps
module testbench
  import csf_pkg::*;
;
  typedef struct {int kind; logic [7:0] val;} csf_note_s;
  logic         clk_sys_i   = 1'b0;
  logic         arst_n_i    = 1'b0;
  csf_sfr_req_s sfr_i       = '0;
  logic         acc_wr_i    = 1'b0;
  logic [7:0]   acc_wdata_i = 8'h00;
  csf_alu_req_s alu_i       = '{1'b0, CSF_OP_NONE, 8'h00};
  csf_instr_s   instr_i     = '0;
  logic [7:0]   sfr_rdata_o, acc_o, b_o, psw_o;
  logic [4:0]   bank_base_o;
  logic         instr_ready_o, instr_done_o;
  int           num_errors = 0, compares = 0, cyc = 0;
  logic [7:0]   m_acc = 8'h00, m_b = 8'h00, m_psw = 8'h00;
  csf_note_s    nq[$];
  int           take_q[$], n_q[$];
  csf_op_e      dir_op[9] = '{CSF_OP_ADD, CSF_OP_SUM_WITH_CARRY_INSTR, CSF_OP_SUBTRACT_BORROW_INSTR, CSF_OP_SUBTRACT_BORROW_INSTR, CSF_OP_MUL,
                              CSF_OP_MUL, CSF_OP_DIV, CSF_OP_DIV, CSF_OP_NONE};
  logic [7:0]   dv[9][3] = '{'{8'h7F, 8'h00, 8'h01}, '{8'h0F, 8'h00, 8'hF0},
                            '{8'h00, 8'h00, 8'h01}, '{8'h80, 8'h00, 8'h01},
                            '{8'h20, 8'h10, 8'h00}, '{8'h05, 8'h03, 8'h00},
                            '{8'h37, 8'h00, 8'h00}, '{8'hFB, 8'h0A, 8'h00},
                            '{8'h42, 8'h11, 8'h99}};

  always #25 clk_sys_i = ~clk_sys_i;

  csf_status_core csf_status_core_i (.clk_sys_i, .arst_n_i, .sfr_i, .sfr_rdata_o, .acc_wr_i,
    .acc_wdata_i, .alu_i, .instr_i, .instr_ready_o, .instr_done_o, .acc_o, .b_o, .psw_o,
    .bank_base_o);

  // ==================================================================
  // Checking
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_n(input int e, input int g);
    compares++;
    if (g != e) begin
      num_errors++;
      $display("wrong value instruction clocks expected %0d seen %0d", e, g);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Settled outputs are looked at half a cycle after each launching edge
  always @(negedge clk_sys_i) begin
    csf_note_s n;
    while (nq.size() > 0) begin
      n = nq.pop_front();
      case (n.kind)
        0: cmp8("acc", n.val, acc_o);
        1: cmp8("second acc", n.val, b_o);
        2: cmp8("status", n.val, psw_o);
        3: cmp8("read data", n.val, sfr_rdata_o);
        4: cmp8("bank base", n.val, {3'h0, bank_base_o});
        default: cmp8("ready", n.val, {7'h00, instr_ready_o});
      endcase
    end
  end

  // Done pulses are paired with takes in order; a refused request leaves no take
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    // Registered done is seen one edge after the last busy clock
    if (instr_done_o === 1'b1) begin
      if (n_q.size() == 0 || take_q.size() == 0) cmp_n(0, 1);
      else cmp_n(n_q.pop_front(), cyc - take_q.pop_front() - 1);
    end
    if (instr_i.valid && instr_ready_o === 1'b1) take_q.push_back(cyc);
    if (cyc > 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ==================================================================
  // Drivers with reference model
  task automatic note(input int k, input logic [7:0] v);
    nq.push_back('{k, v});
  endtask

  task automatic state_note();
    note(0, m_acc);
    note(1, m_b);
    note(2, {m_psw[7:1], ^m_acc});
  endtask

  task automatic sfr(input logic w, bwr, r, input logic [7:0] a, d,
                     input logic [2:0] i, input logic v);
    sfr_i <= '{w, bwr, r, a, d, i, v};
    @(posedge clk_sys_i);
    sfr_i <= '0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr(1'b1, 1'b0, 1'b0, a, d, 3'h0, 1'b0);
    if (a == 8'hD0) m_psw = d & 8'hFE;
    if (a == 8'hF0) m_b = d;
  endtask

  task automatic bw(input logic [7:0] a, input logic [2:0] i, input logic v);
    sfr(1'b0, 1'b1, 1'b0, a, 8'h00, i, v);
    if (a == 8'hD0 && i != 3'h0) m_psw[i] = v;
    if (a == 8'hF0) m_b[i] = v;
  endtask

  task automatic rd(input logic [7:0] a);
    sfr(1'b0, 1'b0, 1'b1, a, 8'h00, 3'h0, 1'b0);
    note(3, a == 8'hD0 ? {m_psw[7:1], ^m_acc} : (a == 8'hF0 ? m_b : 8'h00));
  endtask

  task automatic ld(input logic [7:0] v);
    acc_wr_i    <= 1'b1;
    acc_wdata_i <= v;
    @(posedge clk_sys_i);
    acc_wr_i <= 1'b0;
    @(posedge clk_sys_i);
    m_acc = v;
  endtask

  task automatic alu(input csf_op_e op, input logic [7:0] s);
    logic [8:0]  r;
    logic [4:0]  h;
    logic [15:0] p;
    logic        c;
    c = (op == CSF_OP_SUBTRACT_BORROW_INSTR || op == CSF_OP_SUM_WITH_CARRY_INSTR) && m_psw[7];
    if (op == CSF_OP_ADD || op == CSF_OP_SUM_WITH_CARRY_INSTR) begin
      r = 9'(m_acc) + 9'(s) + 9'(c);
      h = 5'(m_acc[3:0]) + 5'(s[3:0]) + 5'(c);
      m_psw[2] = (m_acc[7] == s[7]) && (r[7] != m_acc[7]);
    end else if (op == CSF_OP_SUBTRACT_BORROW_INSTR) begin
      r = 9'(m_acc) - 9'(s) - 9'(c);
      h = 5'(m_acc[3:0]) - 5'(s[3:0]) - 5'(c);
      m_psw[2] = (m_acc[7] != s[7]) && (r[7] != m_acc[7]);
    end
    if (op == CSF_OP_ADD || op == CSF_OP_SUM_WITH_CARRY_INSTR || op == CSF_OP_SUBTRACT_BORROW_INSTR) begin
      m_psw[7] = r[8];
      m_psw[6] = h[4];
      m_acc    = r[7:0];
    end else if (op == CSF_OP_MUL) begin
      p        = m_acc * m_b;
      m_psw[7] = 1'b0;
      m_psw[2] = p > 16'h00FF;
      m_acc    = p[7:0];
      m_b      = p[15:8];
    end else if (op == CSF_OP_DIV) begin
      m_psw[7] = 1'b0;
      m_psw[2] = m_b == 8'h00;
      if (m_b != 8'h00) begin
        p[7:0] = m_acc / m_b;
        m_b    = m_acc % m_b;
        m_acc  = p[7:0];
      end
    end
    alu_i <= '{1'b1, op, s};
    @(posedge clk_sys_i);
    alu_i <= '{1'b0, CSF_OP_NONE, 8'h00};
    @(posedge clk_sys_i);
  endtask

  // Holds the request until it is taken; the caller releases it
  task automatic ins(input logic [1:0] n, input logic cb, input logic tk);
    n_q.push_back(int'(n) + int'(cb && tk));
    instr_i <= '{1'b1, n, cb, tk};
    do @(posedge clk_sys_i); while (instr_ready_o !== 1'b1);
  endtask

  // ==================================================================
  // Scenarios
  initial begin
    void'($urandom(32'h68b6));
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    state_note();
    note(4, 8'h00);
    note(5, 8'h01);
    @(posedge clk_sys_i);
    rd(8'hF0);
    wr(8'hD0, 8'hFF);
    state_note();
    rd(8'hD0);
    for (int i = 0; i < 4; i++) begin
      wr(8'hD0, 8'(i << 3));
      note(4, 8'(i << 3));
    end
    bw(8'hD0, 3'h0, 1'b1);
    bw(8'hD0, 3'h5, 1'b1);
    bw(8'hD0, 3'h1, 1'b1);
    bw(8'hF0, 3'h7, 1'b1);
    wr(8'hE0, 8'h55);
    rd(8'hE0);
    state_note();
    ld(8'h07);
    state_note();
    ld(8'hFF);
    alu(CSF_OP_ADD, 8'h01);
    state_note();
    foreach (dir_op[i]) begin
      ld(dv[i][0]);
      wr(8'hF0, dv[i][1]);
      alu(dir_op[i], dv[i][2]);
      state_note();
    end
    for (int i = 0; i < 60; i++) begin
      wr(8'hD0, 8'($urandom));
      ld(8'($urandom));
      wr(8'hF0, 8'($urandom));
      alu(dir_op[$urandom % 9], 8'($urandom));
      state_note();
    end
    for (int n = 1; n < 4; n++)
      for (int k = 0; k < 4; k++) begin
        ins(2'(n), k[1], k[0]);
        instr_i <= '0;
        @(posedge clk_sys_i);
      end
    repeat (3) ins(2'h1, 1'b0, 1'b0);
    ins(2'h3, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    instr_i <= '0;
    repeat (6) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule
